// ==== mcf_params.svh ====
`ifndef MCF_PARAMS_SVH
`define MCF_PARAMS_SVH

// *****************************************************************
// Timing counts
// *****************************************************************
`define MCF_MIN_CYC    4
`define MCF_MAX_CYC    12
`define MCF_STALL_CYC  4
`define MCF_OFF_WAIT   1

// *****************************************************************
// Field positions and reset values
// *****************************************************************
`define MCF_SHUT_BIT   5
`define MCF_WORD_RST   16'h0000
`define MCF_FLAG_RST   4'h0
`define MCF_BUMP_WORD  1'b1

`endif

// ==== mcf_pkg.sv ====
package mcf_pkg;

   // Six architectural states, Gray coded along fetch-decode-exec-wback.
   typedef enum logic [2:0] {
      MCF_HOLD   = 3'h0,
      MCF_RESET  = 3'h1,
      MCF_FETCH  = 3'h3,
      MCF_DECODE = 3'h2,
      MCF_EXEC   = 3'h6,
      MCF_WBACK  = 3'h7
   } mcf_state_t;

   // Sub-phase kept beside the main state.
   typedef enum logic [2:0] {
      MCF_RUN   = 3'h0,
      MCF_SUM   = 3'h1,
      MCF_STALL = 3'h3,
      MCF_IDLE  = 3'h2,
      MCF_OFF   = 3'h6
   } mcf_phase_t;

   typedef enum logic [2:0] {
      MCF_F_INSTR   = 3'h0,
      MCF_F_IMM     = 3'h1,
      MCF_F_INDEXED = 3'h2,
      MCF_F_IDX_SRC = 3'h3,
      MCF_F_IDX_DST = 3'h4,
      MCF_F_IND     = 3'h5,
      MCF_F_POSTINC = 3'h6,
      MCF_F_VECTOR  = 3'h7
   } mcf_ftype_t;

   typedef enum logic [2:0] {
      MCF_M_REG = 3'h0,
      MCF_M_IMM = 3'h1,
      MCF_M_IDX = 3'h2,
      MCF_M_IND = 3'h3,
      MCF_M_INC = 3'h4
   } mcf_mode_t;

   typedef enum logic [1:0] {
      MCF_C_BRANCH = 2'h0,
      MCF_C_SINGLE = 2'h1,
      MCF_C_TWO    = 2'h2,
      MCF_C_CROSS  = 2'h3
   } mcf_class_t;

   typedef struct packed {
      logic       illegal;
      mcf_class_t cls;
      logic [3:0] op;
      mcf_mode_t  smode;
      mcf_mode_t  dmode;
      logic       byte_mode;
   } mcf_dec_t;

   typedef struct packed {
      logic c;
      logic v;
      logic n;
      logic z;
   } mcf_flags_t;

endpackage

// ==== mcf_control.sv ====
// Contract
// - controller is always in exactly one of six states.
// - every machine cycle takes at least four clocks; an interrupt cycle here takes three.
// - longest instruction finishes within twelve clocks.
// - after power-up wait in hold until configuration completes.
// - skip report arrives after one clock, then go to reset.
// - reset clears interrupt buffer and control registers.
// - each machine cycle starts in fetch, serving one of eight types.
// - instruction fetch checks interrupts, reads memory, goes decode.
// - immediate fetch reads next word into ALU source, then execute.
// - indexed fetch reads offset and base register, then sum.
// - sum adds base and offset onto address, back to fetch.
// - operand fetch loads effective address data into the operand.
// - source indexed operand is always fetched before destination.
// - indirect fetch reads at register address into ALU source.
// - post-increment bumps pointer by one or two after use.
// - interrupt loads handler address into program counter, then wback.
// - idle request holds idle, polling the reset interrupt flag.
// - shutdown bit gives one idle clock, then off.
// - ALU routes operands by class, operation by opcode.
// - ALU makes carry, overflow, negative, zero into flag register.
// - ALU holds result in output register and signals completion.
// - decode runs once per machine cycle, then execute.
// - unknown instruction abandons cycle and stalls four clocks.
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ns
`include "mcf_params.svh"
module mcf_control
   import mcf_pkg::*;
#(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst_b,
   input  wire logic       clk_en,
   // Configuration controller
   input  wire logic       cfg_done,
   input  wire logic       cfg_skip,
   // Decoder
   input  wire mcf_dec_t   dec,
   output      logic       dec_start,
   // Interrupts and run control
   input  wire logic       irq_raise,
   input  wire logic [W-1:0] irq_vector,
   input  wire logic       reset_irq,
   input  wire logic       idle_req,
   input  wire logic [7:0] run_control_reg,
   // Data sources
   input  wire logic [W-1:0] pc_value,
   input  wire logic [W-1:0] mem_rdata,
   input  wire logic [W-1:0] rf_src_data,
   input  wire logic [W-1:0] rf_dst_data,
   // Memory unit
   output      logic       mem_rd,
   output      logic       mem_wr,
   output      logic [W-1:0] mem_addr,
   // Register file
   output      logic       rf_rd_req,
   output      logic       rf_wr,
   output      logic       pc_load,
   output      logic [W-1:0] rf_wr_data,
   output      logic       pointer_bump_request,
   output      logic       bump_two,
   output      logic       flag_wr,
   output      mcf_flags_t flag_register,
   // ALU result and status
   output      logic [W-1:0] alu_result,
   output      logic       alu_done,
   output      logic       irq_pending,
   output      logic       powered_off,
   output      mcf_state_t state_now
);

   // *****************************************************************
   // Parameter check
   // *****************************************************************
   if (W < 8) begin : g_bad_width
      $error("mcf_control needs W of at least 8");
   end

   // *****************************************************************
   // State
   // *****************************************************************
   mcf_state_t state;
   mcf_phase_t phase;
   mcf_ftype_t ftype;
   mcf_dec_t   inst;
   logic       idx_dst, got_src, got_dst, cap_src, cap_dst, from_vec;
   logic [2:0] stall_cnt;
   logic [W-1:0] src_op, dst_op, dst_addr;
   logic [W-1:0] a_in, b_in, ea_sum;
   logic [W:0] sum_ext;
   logic       shut;

   assign shut = run_control_reg[`MCF_SHUT_BIT];
   assign ea_sum = mem_rdata +
                   (idx_dst ? rf_dst_data : rf_src_data);

   // Operand bypass: data captured this cycle feeds the ALU directly.
   always_comb begin
      a_in = cap_src ? mem_rdata : src_op;
      b_in = cap_dst ? mem_rdata : dst_op;
      unique case (inst.cls)
         MCF_C_BRANCH: begin
            a_in = pc_value;
         end
         MCF_C_SINGLE: begin
            b_in = '0;
         end
         MCF_C_TWO: begin
         end
         MCF_C_CROSS: begin
            b_in = '0;
         end
      endcase
      sum_ext = {1'b0, a_in} + {1'b0, b_in};
   end

   // *****************************************************************
   // Sequencer
   // *****************************************************************
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state <= MCF_HOLD;
         phase <= MCF_RUN;
         ftype <= MCF_F_INSTR;
         stall_cnt <= '0;
      end else if (clk_en) begin
         unique case (state)
            MCF_HOLD: begin
               if (cfg_done || cfg_skip) begin
                  state <= MCF_RESET;
               end
            end
            MCF_RESET: begin
               state <= MCF_FETCH;
               phase <= MCF_RUN;
               ftype <= MCF_F_INSTR;
            end
            MCF_FETCH: begin
               if (phase == MCF_SUM) begin
                  phase <= MCF_RUN;
                  ftype <= idx_dst ? MCF_F_IDX_DST : MCF_F_IDX_SRC;
               end else if (phase == MCF_IDLE) begin
                  if (shut) begin
                     phase <= MCF_OFF;
                  end else if (reset_irq) begin
                     state <= MCF_RESET;
                  end
               end else if (phase == MCF_OFF) begin
                  phase <= MCF_OFF;
               end else begin
                  unique case (ftype)
                     MCF_F_INSTR: begin
                        if (shut || idle_req) begin
                           phase <= MCF_IDLE;
                        end else if (irq_pending) begin
                           ftype <= MCF_F_VECTOR;
                        end else begin
                           state <= MCF_DECODE;
                        end
                     end
                     MCF_F_INDEXED: begin
                        phase <= MCF_SUM;
                     end
                     MCF_F_VECTOR: begin
                        state <= MCF_WBACK;
                     end
                     default: begin
                        state <= MCF_EXEC;
                     end
                  endcase
               end
            end
            MCF_DECODE: begin
               if (phase == MCF_STALL) begin
                  stall_cnt <= stall_cnt - 3'h1;
                  if (stall_cnt == 3'h1) begin
                     state <= MCF_FETCH;
                     phase <= MCF_RUN;
                     ftype <= MCF_F_INSTR;
                  end
               end else if (dec.illegal) begin
                  phase <= MCF_STALL;
                  stall_cnt <= 3'(`MCF_STALL_CYC);
               end else begin
                  state <= MCF_EXEC;
               end
            end
            MCF_EXEC: begin
               if (inst.smode != MCF_M_REG && !got_src) begin
                  state <= MCF_FETCH;
                  unique case (inst.smode)
                     MCF_M_IMM: ftype <= MCF_F_IMM;
                     MCF_M_IND: ftype <= MCF_F_IND;
                     MCF_M_INC: ftype <= MCF_F_POSTINC;
                     default:   ftype <= MCF_F_INDEXED;
                  endcase
               end else if (inst.dmode == MCF_M_IDX && !got_dst) begin
                  state <= MCF_FETCH;
                  ftype <= MCF_F_INDEXED;
               end else begin
                  state <= MCF_WBACK;
               end
            end
            MCF_WBACK: begin
               state <= MCF_FETCH;
               ftype <= MCF_F_INSTR;
            end
         endcase
      end
   end

   // *****************************************************************
   // Operand bookkeeping
   // *****************************************************************
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         inst <= '0;
         idx_dst <= 1'b0;
         got_src <= 1'b0;
         got_dst <= 1'b0;
         cap_src <= 1'b0;
         cap_dst <= 1'b0;
         from_vec <= 1'b0;
         src_op <= `MCF_WORD_RST;
         dst_op <= `MCF_WORD_RST;
         dst_addr <= `MCF_WORD_RST;
      end else if (clk_en) begin
         cap_src <= 1'b0;
         cap_dst <= 1'b0;
         if (state == MCF_RESET) begin
            inst <= '0;
            got_src <= 1'b0;
            got_dst <= 1'b0;
            from_vec <= 1'b0;
         end
         if (state == MCF_DECODE && phase == MCF_RUN) begin
            inst <= dec;
            got_src <= 1'b0;
            got_dst <= 1'b0;
            idx_dst <= 1'b0;
            from_vec <= 1'b0;
            src_op <= rf_src_data;
            dst_op <= rf_dst_data;
         end
         if (state == MCF_EXEC) begin
            if (cap_src) src_op <= mem_rdata;
            if (cap_dst) dst_op <= mem_rdata;
            idx_dst <= !(inst.smode != MCF_M_REG && !got_src);
         end
         if (state == MCF_FETCH && phase == MCF_RUN) begin
            unique case (ftype)
               MCF_F_IMM, MCF_F_IND, MCF_F_POSTINC, MCF_F_IDX_SRC: begin
                  cap_src <= 1'b1;
                  got_src <= 1'b1;
               end
               MCF_F_IDX_DST: begin
                  cap_dst <= 1'b1;
                  got_dst <= 1'b1;
                  dst_addr <= mem_addr;
               end
               MCF_F_VECTOR: begin
                  from_vec <= 1'b1;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // *****************************************************************
   // Interrupt buffer: a new request beats the clear.
   // *****************************************************************
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         irq_pending <= 1'b0;
      end else if (clk_en) begin
         if (irq_raise) begin
            irq_pending <= 1'b1;
         end else if (state == MCF_RESET) begin
            irq_pending <= 1'b0;
         end else if (state == MCF_FETCH && ftype == MCF_F_VECTOR &&
                      phase == MCF_RUN) begin
            irq_pending <= 1'b0;
         end
      end
   end

   // *****************************************************************
   // Memory and register file strobes
   // *****************************************************************
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         mem_addr <= `MCF_WORD_RST;
         rf_rd_req <= 1'b0;
         rf_wr <= 1'b0;
         pc_load <= 1'b0;
         rf_wr_data <= `MCF_WORD_RST;
         pointer_bump_request <= 1'b0;
         bump_two <= 1'b0;
         dec_start <= 1'b0;
         powered_off <= 1'b0;
         state_now <= MCF_HOLD;
      end else if (clk_en) begin
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         rf_rd_req <= 1'b0;
         rf_wr <= 1'b0;
         pc_load <= 1'b0;
         pointer_bump_request <= 1'b0;
         dec_start <= state == MCF_DECODE && phase == MCF_RUN;
         powered_off <= phase == MCF_OFF;
         state_now <= state;
         if (state == MCF_FETCH && phase == MCF_SUM) begin
            mem_addr <= ea_sum;
         end
         if (state == MCF_FETCH && phase == MCF_RUN) begin
            unique case (ftype)
               MCF_F_INSTR: begin
                  if (!(shut || idle_req || irq_pending)) begin
                     mem_rd <= 1'b1;
                     mem_addr <= pc_value;
                  end
               end
               MCF_F_IMM, MCF_F_INDEXED: begin
                  mem_rd <= 1'b1;
                  mem_addr <= pc_value;
                  rf_rd_req <= ftype == MCF_F_INDEXED;
               end
               MCF_F_IDX_SRC, MCF_F_IDX_DST: begin
                  mem_rd <= 1'b1;
               end
               MCF_F_IND, MCF_F_POSTINC: begin
                  mem_rd <= 1'b1;
                  mem_addr <= rf_src_data;
                  pointer_bump_request <= ftype == MCF_F_POSTINC;
                  bump_two <= inst.byte_mode != `MCF_BUMP_WORD;
               end
               MCF_F_VECTOR: begin
                  rf_wr <= 1'b1;
                  pc_load <= 1'b1;
                  rf_wr_data <= irq_vector;
               end
            endcase
         end
         if (state == MCF_WBACK && !from_vec) begin
            if (inst.cls == MCF_C_TWO && inst.dmode == MCF_M_IDX) begin
               mem_wr <= 1'b1;
               mem_addr <= dst_addr;
            end else if (inst.cls != MCF_C_CROSS) begin
               rf_wr <= 1'b1;
               pc_load <= inst.cls == MCF_C_BRANCH;
               rf_wr_data <= alu_result;
            end
         end
      end
   end

   // *****************************************************************
   // ALU execution: result and flags land together.
   // *****************************************************************
   logic [W-1:0] res;
   logic         cy, ov;

   always_comb begin
      res = sum_ext[W-1:0];
      cy = sum_ext[W];
      ov = (a_in[W-1] == b_in[W-1]) && (res[W-1] != a_in[W-1]);
      unique case (inst.op)
         4'h1: begin
            res = a_in - b_in;
            cy = a_in >= b_in;
            ov = (a_in[W-1] != b_in[W-1]) && (res[W-1] != a_in[W-1]);
         end
         4'h2: begin
            res = a_in & b_in;
            cy = 1'b0;
            ov = 1'b0;
         end
         4'h3: begin
            res = a_in | b_in;
            cy = 1'b0;
            ov = 1'b0;
         end
         4'h4: begin
            res = a_in ^ b_in;
            cy = 1'b0;
            ov = 1'b0;
         end
         4'h5: begin
            res = a_in;
            cy = 1'b0;
            ov = 1'b0;
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         alu_result <= `MCF_WORD_RST;
         alu_done <= 1'b0;
         flag_wr <= 1'b0;
         flag_register <= `MCF_FLAG_RST;
      end else if (clk_en) begin
         alu_done <= 1'b0;
         flag_wr <= 1'b0;
         if (state == MCF_EXEC && !(inst.smode != MCF_M_REG && !got_src)
             && !(inst.dmode == MCF_M_IDX && !got_dst)) begin
            alu_result <= res;
            alu_done <= 1'b1;
            flag_wr <= 1'b1;
            flag_register <= '{c: cy, v: ov, n: res[W-1],
                               z: res == '0};
         end
      end
   end

   // *****************************************************************
   // Checks; they count only enabled edges.
   // *****************************************************************
   default clocking cb @(posedge clock iff clk_en);
   endclocking
   default disable iff (!rst_b);

   logic [3:0] mc_cnt;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         mc_cnt <= '0;
      end else if (clk_en) begin
         mc_cnt <= (state == MCF_WBACK || state == MCF_RESET ||
                    phase == MCF_STALL) ? 4'h0 :
                   (mc_cnt == 4'hF ? mc_cnt : mc_cnt + 4'h1);
      end
   end

   sequence s_skip;
      state == MCF_HOLD && cfg_skip;
   endsequence
   sequence s_ready;
      state == MCF_RESET ##1 state == MCF_FETCH;
   endsequence

   chk_six_states: assert property (
      state inside {MCF_HOLD, MCF_RESET, MCF_FETCH, MCF_DECODE,
                    MCF_EXEC, MCF_WBACK})
      else $error("state code outside the six states");
   chk_cycle_len: assert property (
      state == MCF_WBACK && !from_vec |->
         mc_cnt >= 4'(`MCF_MIN_CYC - 1) && mc_cnt <= 4'(`MCF_MAX_CYC - 1))
      else $error("machine cycle length out of range");
   chk_hold_wait: assert property (
      state == MCF_HOLD && !cfg_done && !cfg_skip |=> state == MCF_HOLD)
      else $error("hold left without configuration");
   chk_skip_reset: assert property (s_skip |=> s_ready)
      else $error("skip did not lead through reset to fetch");
   chk_reset_clear: assert property (
      state == MCF_RESET && !irq_raise |=> !irq_pending)
      else $error("reset did not clear interrupt buffer");
   chk_instr_read: assert property (
      state == MCF_FETCH && phase == MCF_RUN && ftype == MCF_F_INSTR &&
      !shut && !idle_req && !irq_pending |=>
         mem_rd && mem_addr == $past(pc_value) && state == MCF_DECODE)
      else $error("instruction fetch did not read and decode");
   chk_sum_addr: assert property (
      state == MCF_FETCH && phase == MCF_SUM |=>
         mem_addr == $past(mem_rdata) + ($past(idx_dst) ?
         $past(rf_dst_data) : $past(rf_src_data)) && phase == MCF_RUN &&
         ftype inside {MCF_F_IDX_SRC, MCF_F_IDX_DST})
      else $error("effective address not driven");
   chk_bump_ptr: assert property (
      state == MCF_FETCH && phase == MCF_RUN && ftype == MCF_F_POSTINC |=>
         pointer_bump_request && mem_rd && state == MCF_EXEC)
      else $error("post-increment fetch missed bump");
   chk_vector_pc: assert property (
      state == MCF_FETCH && phase == MCF_RUN && ftype == MCF_F_VECTOR |=>
         pc_load && rf_wr && rf_wr_data == $past(irq_vector) &&
         state == MCF_WBACK)
      else $error("handler address not loaded");
   chk_shut_off: assert property (
      state == MCF_FETCH && phase == MCF_IDLE && shut |=>
         phase == MCF_OFF ##1 powered_off)
      else $error("shutdown did not reach off");
   chk_decode_next: assert property (
      state == MCF_DECODE && phase == MCF_RUN && !dec.illegal |=>
         state == MCF_EXEC)
      else $error("decode not followed by execute");
   chk_stall_four: assert property (
      state == MCF_DECODE && phase == MCF_RUN && dec.illegal |=>
         (phase == MCF_STALL && state == MCF_DECODE) [*4] ##1
         (state == MCF_FETCH && ftype == MCF_F_INSTR))
      else $error("illegal word did not stall four clocks");
   chk_alu_done: assert property (
      alu_done |-> flag_wr && state == MCF_WBACK)
      else $error("ALU completion without flags or write back");

endmodule // mcf_control

// ==== mcf_far_model.sv ====
`timescale 1ns/1ns
module mcf_far_model
   import mcf_pkg::*;
(
   // Clock and memory request
   input  wire logic        clock,
   input  wire logic        mem_rd,
   input  wire logic [15:0] mem_addr,
   // Data returned
   output      logic [15:0] mem_rdata,
   output      logic [15:0] rf_src_data,
   output      logic [15:0] rf_dst_data
);
   logic [15:0] junk = 16'h0000;
   assign rf_src_data = 16'h0100;
   assign rf_dst_data = 16'h0200;
   // Data stands only while the read strobe stands; otherwise the bus
   // toggles so that a late capture cannot pass by luck.
   assign mem_rdata = mem_rd ? mem_addr + 16'h0003 : junk;
   always @(posedge clock) begin
      junk <= ~junk;
   end
endmodule // mcf_far_model

// ==== tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
   import mcf_pkg::*;
   // ***************************************
   // Stimulus and observed signals
   // ***************************************
   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   logic        cfg_skip = 1'b0;
   logic        irq_raise = 1'b0;
   logic        clk_en = 1'b1;
   logic        cfg_done = 1'b0;
   logic        idle_req = 1'b0;
   logic        reset_irq = 1'b0;
   logic [7:0]  run_ctl = 8'h00;
   logic [15:0] irq_vec = 16'h0000;
   mcf_dec_t    dec = '0;
   logic        dec_start, mem_rd, pc_load, powered_off;
   logic [15:0] mem_addr, rf_wr_data, mem_rdata, rf_src, rf_dst, alu_res;
   mcf_state_t  st;
   int          n_mismatch = 0;
   int          checked = 0;
   int          n;
   always #20 clock = ~clock;
   mcf_control i_dut (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
      .cfg_done(cfg_done), .cfg_skip(cfg_skip), .dec(dec),
      .dec_start(dec_start), .irq_raise(irq_raise), .irq_vector(irq_vec),
      .reset_irq(reset_irq), .idle_req(idle_req), .run_control_reg(run_ctl),
      .pc_value(16'h0040), .mem_rdata(mem_rdata), .rf_src_data(rf_src),
      .rf_dst_data(rf_dst), .mem_rd(mem_rd), .mem_wr(), .mem_addr(mem_addr),
      .rf_rd_req(), .rf_wr(), .pc_load(pc_load), .rf_wr_data(rf_wr_data),
      .pointer_bump_request(), .bump_two(), .flag_wr(), .flag_register(),
      .alu_result(alu_res), .alu_done(), .irq_pending(),
      .powered_off(powered_off),
      .state_now(st));
   mcf_far_model i_far (.clock(clock), .mem_rd(mem_rd), .mem_addr(mem_addr),
      .mem_rdata(mem_rdata), .rf_src_data(rf_src), .rf_dst_data(rf_dst));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      if (n_mismatch == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Cycles until the signal chosen by sel is seen high (sel 3: state seen at reset), bounded at 60.
   task automatic wait_hi(input int sel, output int c);
      c = 0;
      do begin
         @(posedge clock);
         c++;
      end while (c < 60 && ((sel == 0) ? dec_start !== 1'b1 :
                 (sel == 1) ? pc_load !== 1'b1 :
                 (sel == 2) ? powered_off !== 1'b1 : st !== MCF_RESET));
   endtask
   task automatic t_hold;
      repeat (6) @(posedge clock);
      check(16'(st), 16'(MCF_HOLD));
      cfg_skip <= 1'b1;
      n = 0;
      while (st !== MCF_RESET && n < 5) begin
         @(posedge clock);
         n++;
      end
      check(16'(st), 16'(MCF_RESET));
      @(posedge clock);
      check(16'(st), 16'(MCF_FETCH));
   endtask
   task automatic t_len(input mcf_mode_t s, input mcf_mode_t d, input int e,
                        input logic [15:0] r);
      dec <= '{1'b0, MCF_C_TWO, 4'h0, s, d, 1'b0};
      wait_hi(0, n);
      wait_hi(0, n);
      wait_hi(0, n);
      check(16'(n), 16'(e));
      check(alu_res, r);
   endtask
   task automatic t_irq;
      irq_vec <= 16'h4C00;
      irq_raise <= 1'b1;
      @(posedge clock);
      irq_raise <= 1'b0;
      wait_hi(1, n);
      check(rf_wr_data, 16'h4C00);
   endtask
   task automatic t_off;
      run_ctl <= 8'h20;
      wait_hi(2, n);
      check({15'h0000, powered_off}, 16'h0001);
      check(16'(n), 16'h0004);
   endtask
   task automatic t_stall;
      dec <= '{1'b1, MCF_C_TWO, 4'h0, MCF_M_REG, MCF_M_REG, 1'b0};
      wait_hi(0, n);
      wait_hi(0, n);
      wait_hi(0, n);
      check(16'(n), 16'h0006);
   endtask
   // A reset interrupt raised while the clock is blocked must wait.
   task automatic t_idle;
      idle_req <= 1'b1;
      repeat (16) @(posedge clock);
      idle_req <= 1'b0;
      check(16'(st), 16'(MCF_FETCH));
      clk_en <= 1'b0;
      reset_irq <= 1'b1;
      repeat (6) @(posedge clock);
      check(16'(st), 16'(MCF_FETCH));
      clk_en <= 1'b1;
      wait_hi(3, n);
      check(16'(st), 16'(MCF_RESET));
      reset_irq <= 1'b0;
   endtask
   task automatic t_cfg;
      rst_b <= 1'b0;
      cfg_skip <= 1'b0;
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      repeat (8) @(posedge clock);
      check(16'(st), 16'(MCF_HOLD));
      cfg_done <= 1'b1;
      wait_hi(3, n);
      check(16'(n), 16'h0003);
   endtask
   initial begin
      #(40 * 4000);
      n_mismatch++;
      summarize;
   end
   initial begin
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
      t_hold;
      t_len(MCF_M_REG, MCF_M_REG, 4, 16'h0300);
      t_len(MCF_M_IMM, MCF_M_REG, 6, 16'h0243);
      t_len(MCF_M_IDX, MCF_M_REG, 8, 16'h0346);
      t_len(MCF_M_IND, MCF_M_REG, 6, 16'h0303);
      t_len(MCF_M_INC, MCF_M_REG, 6, 16'h0303);
      t_len(MCF_M_IDX, MCF_M_IDX, 12, 16'h038C);
      t_stall;
      t_idle;
      t_irq;
      t_off;
      t_cfg;
      summarize;
   end
endmodule // tb_top
